// ---- rtl/osm_pkg.sv ----
// Shared constants and types for the output sync and mute controller.
package osm_pkg;

  // Channel counts: output channels, post-dividers (PLL outputs), pins, CMOS channels.
  localparam int NCH   = 8;
  localparam int NSRC  = 4;
  localparam int NPIN  = 2;
  localparam int NCMOS = 2;
  localparam int SELW  = 2;

  // Pin function code that turns a pin into the alignment input.
  localparam logic [5:0] PIN_FUNC_SYNC = 6'h1f;

  // Divider bypass ratio and reset values.
  localparam logic [11:0] DIV_BYPASS  = 12'h001;
  localparam logic [11:0] DIV_RST_VAL = 12'h000;

  // Per-pin CMOS mode encodings.
  typedef enum logic [1:0] {
    OSM_CMOS_NORMAL = 2'b00,
    OSM_CMOS_INVERT = 2'b01,
    OSM_CMOS_HIZ    = 2'b10,
    OSM_CMOS_LOW    = 2'b11
  } osm_cmos_mode_t;

  // Alignment sequencer states.
  typedef enum logic [1:0] {
    OSM_RUN  = 2'b00,
    OSM_HOLD = 2'b01,
    OSM_REL  = 2'b10
  } osm_state_t;

endpackage

// ---- rtl/osm_sync_if.sv ----
// Interface carrying the per-pin alignment request into the sync stage.
`timescale 1ns/1ps
interface osm_sync_if;
  logic raw;
  logic synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// ---- rtl/osm_sync3.sv ----
// Three-stage synchroniser with agreement filter for an outside level.
`timescale 1ns/1ps
module osm_sync3 (
  input  wire logic clk,
  input  wire logic rst,
  osm_sync_if.dst   sif
);
  import osm_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } osm_sync_st_t;

  osm_sync_st_t st_q;
  osm_sync_st_t st_d;

  // The output changes only once stages two and three agree.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = sif.raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.out = st_q.s3;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sif.synced = st_q.out;
endmodule

// ---- rtl/osm_top.sv ----
// Output channel alignment, auto-mute, CMOS pin mode and pin replica control.
// The block runs in one clock domain standing for the PLL output clocks; each
// source has its own hold/release sequencer so groups stay separate.
`timescale 1ns/1ps
module osm_top (
  input  wire logic                                       clk,
  input  wire logic                                       rst,
  input  wire logic                                       global_align_enable,
  input  wire logic                                       software_align_trigger,
  input  wire logic [osm_pkg::NPIN-1:0][5:0]              pin_function_select,
  input  wire logic [osm_pkg::NPIN-1:0]                   pin_polarity_invert,
  input  wire logic [osm_pkg::NPIN-1:0]                   pin_in,
  input  wire logic [osm_pkg::NPIN-1:0]                   pin_output_enable,
  input  wire logic [osm_pkg::NCH-1:0]                    divider_align_enable,
  input  wire logic [osm_pkg::NCH-1:0]                    sysref_divider_align_enable,
  input  wire logic [osm_pkg::NCH-1:0]                    sysref_pin_replicate_enable,
  input  wire logic [osm_pkg::NCH-1:0]                    output_mute_enable,
  input  wire logic [osm_pkg::NCH-1:0][osm_pkg::SELW-1:0] channel_source_select,
  input  wire logic [osm_pkg::NCH-1:0][11:0]              channel_divide_ratio,
  input  wire logic [osm_pkg::NCH-1:0]                    channel_clock_in,
  input  wire logic [osm_pkg::NCH-1:0]                    sysref_static_delayed_in,
  input  wire logic [osm_pkg::NSRC-1:0]                   postdiv_align_enable,
  input  wire logic [osm_pkg::NSRC-1:0]                   analog_pll_locked,
  input  wire logic [osm_pkg::NSRC-1:0]                   digital_pll_freq_locked,
  input  wire logic [osm_pkg::NSRC-1:0]                   digital_pll_phase_locked,
  input  wire logic [osm_pkg::NSRC-1:0]                   mute_on_analog_pll_unlock,
  input  wire logic [osm_pkg::NSRC-1:0]                   mute_on_digital_pll_unlock,
  input  wire logic [osm_pkg::NSRC-1:0]                   mute_on_digital_phase_unlock,
  input  wire osm_pkg::osm_cmos_mode_t [osm_pkg::NCMOS-1:0] cmos_p_mode,
  input  wire osm_pkg::osm_cmos_mode_t [osm_pkg::NCMOS-1:0] cmos_n_mode,
  output logic [osm_pkg::NCH-1:0]                         channel_divider_reset,
  output logic [osm_pkg::NCH-1:0]                         sysref_divider_reset,
  output logic [osm_pkg::NCH-1:0]                         channel_clock_out,
  output logic [osm_pkg::NSRC-1:0]                        postdiv_reset,
  output logic [osm_pkg::NSRC-1:0]                        source_valid,
  output logic [osm_pkg::NCMOS-1:0]                       cmos_p_out,
  output logic [osm_pkg::NCMOS-1:0]                       cmos_p_oe,
  output logic [osm_pkg::NCMOS-1:0]                       cmos_n_out,
  output logic [osm_pkg::NCMOS-1:0]                       cmos_n_oe,
  output logic [osm_pkg::NPIN-1:0]                        pin_out,
  output logic [osm_pkg::NPIN-1:0]                        pin_oe,
  output logic                                            sync_active
);
  import osm_pkg::*;

  typedef struct packed {
    osm_state_t [NSRC-1:0] state;
    logic [NSRC-1:0]       hold;
    logic [NSRC-1:0]       started;
    logic [NCH-1:0]        ch_rst;
    logic [NCH-1:0]        sr_rst;
    logic [NCH-1:0]        ch_out;
    logic [NSRC-1:0]       pd_rst;
    logic [NSRC-1:0]       valid;
    logic [NCMOS-1:0]      p_out;
    logic [NCMOS-1:0]      p_oe;
    logic [NCMOS-1:0]      n_out;
    logic [NCMOS-1:0]      n_oe;
    logic [NPIN-1:0]       g_out;
    logic [NPIN-1:0]       g_oe;
    logic                  active;
  } osm_st_t;

  osm_st_t st_q;
  osm_st_t st_d;

  logic [NPIN-1:0] pin_sync;
  logic            pin_req;
  logic            sync_req;
  logic            any_replica;
  logic            replica_clk;

  // Each pin passes the three-flop filter before any decision uses it.
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      osm_sync_if sif ();
      assign sif.raw = pin_in[gp];
      assign pin_sync[gp] = sif.synced;
      osm_sync3 u_sync (
        .clk (clk),
        .rst (rst),
        .sif (sif)
      );
    end
  endgenerate

  // Combined request: a pin in sync function with its polarity, or software.
  always_comb begin
    pin_req = 1'b0;
    for (int i = 0; i < NPIN; i++) begin
      if (pin_function_select[i] == PIN_FUNC_SYNC) begin
        pin_req = pin_req | (pin_sync[i] ^ pin_polarity_invert[i]);
      end
    end
    sync_req = (pin_req | software_align_trigger) & global_align_enable;
  end

  // Replica source: OR of the static-delayed sysref of each replicating channel.
  always_comb begin
    any_replica = |sysref_pin_replicate_enable;
    replica_clk = |(sysref_pin_replicate_enable & sysref_static_delayed_in);
  end

  // Main next-state logic; every output is a flop of this struct.
  always_comb begin
    logic [NSRC-1:0] rel;
    rel  = '0;
    st_d = st_q;

    // Per-source sequencer: a group holds while requested, then releases together.
    for (int s = 0; s < NSRC; s++) begin
      case (st_q.state[s])
        OSM_RUN: begin
          if (sync_req && postdiv_align_enable[s]) begin
            st_d.state[s] = OSM_HOLD;
          end
        end
        OSM_HOLD: begin
          if (!sync_req) begin
            st_d.state[s] = OSM_REL;
          end
        end
        OSM_REL: begin
          rel[s]        = 1'b1;
          st_d.state[s] = OSM_RUN;
        end
        default: begin
          st_d.state[s] = OSM_RUN;
        end
      endcase
      st_d.hold[s]   = (st_d.state[s] == OSM_HOLD);
      st_d.pd_rst[s] = st_d.hold[s];
    end

    // Source validity from masked lock status; a held post-divider is invalid.
    for (int s = 0; s < NSRC; s++) begin
      st_d.valid[s] = !(mute_on_analog_pll_unlock[s] && !analog_pll_locked[s]) &&
                      !(mute_on_digital_pll_unlock[s] && !digital_pll_freq_locked[s]) &&
                      !(mute_on_digital_phase_unlock[s] && !digital_pll_phase_locked[s]) &&
                      !st_d.hold[s];
      // Outputs of a source start only once it is valid after a hold or reset.
      if (st_d.hold[s] || !st_d.valid[s]) begin
        st_d.started[s] = 1'b0;
      end else if (!st_q.hold[s]) begin
        st_d.started[s] = 1'b1;
      end
    end

    // Per-channel divider resets and gated clocks.
    for (int c = 0; c < NCH; c++) begin
      logic member;
      logic bypass;
      logic src_ok;
      member = divider_align_enable[c] && st_d.hold[channel_source_select[c]];
      bypass = (channel_divide_ratio[c] == DIV_BYPASS);
      src_ok = st_q.started[channel_source_select[c]];
      st_d.ch_rst[c] = member && !bypass;
      st_d.sr_rst[c] = member && sysref_divider_align_enable[c];
      if (bypass) begin
        st_d.ch_out[c] = channel_clock_in[c] &&
                         !(output_mute_enable[c] && !src_ok);
      end else if (st_d.ch_rst[c]) begin
        st_d.ch_out[c] = 1'b0;
      end else if (output_mute_enable[c] && !src_ok) begin
        st_d.ch_out[c] = 1'b0;
      end else begin
        st_d.ch_out[c] = channel_clock_in[c];
      end
    end

    // CMOS pin modes on the first channels, driven from the gated clock.
    for (int k = 0; k < NCMOS; k++) begin
      st_d.p_oe[k]  = (cmos_p_mode[k] != OSM_CMOS_HIZ);
      st_d.n_oe[k]  = (cmos_n_mode[k] != OSM_CMOS_HIZ);
      st_d.p_out[k] = (cmos_p_mode[k] == OSM_CMOS_NORMAL) ? st_d.ch_out[k] :
                      (cmos_p_mode[k] == OSM_CMOS_INVERT) ? !st_d.ch_out[k] : 1'b0;
      st_d.n_out[k] = (cmos_n_mode[k] == OSM_CMOS_NORMAL) ? st_d.ch_out[k] :
                      (cmos_n_mode[k] == OSM_CMOS_INVERT) ? !st_d.ch_out[k] : 1'b0;
    end

    // Pin replica: continuous, never pulsed, only when enabled as output.
    for (int i = 0; i < NPIN; i++) begin
      st_d.g_oe[i]  = pin_output_enable[i] && any_replica &&
                      (pin_function_select[i] != PIN_FUNC_SYNC);
      st_d.g_out[i] = st_d.g_oe[i] && replica_clk;
    end

    st_d.active = |st_d.hold | |rel;
  end

  // Single state register; async reset loads constants only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Ports come straight from the registered state.
  assign channel_divider_reset = st_q.ch_rst;
  assign sysref_divider_reset  = st_q.sr_rst;
  assign channel_clock_out     = st_q.ch_out;
  assign postdiv_reset         = st_q.pd_rst;
  assign source_valid          = st_q.valid;
  assign cmos_p_out            = st_q.p_out;
  assign cmos_p_oe             = st_q.p_oe;
  assign cmos_n_out            = st_q.n_out;
  assign cmos_n_oe             = st_q.n_oe;
  assign pin_out               = st_q.g_out;
  assign pin_oe                = st_q.g_oe;
  assign sync_active           = st_q.active;
endmodule

// ---- tb/osm_host_src.sv ----
// Host-side trigger source that drives the alignment pins.
`timescale 1ns/1ps
module osm_host_src import osm_pkg::*; (
  input  wire logic            clk,
  input  wire logic            want,
  input  wire logic [NPIN-1:0] pol,
  output logic      [NPIN-1:0] pin
);
  // The pin level is the request seen through the polarity, moved just after an edge.
  initial pin = '0;
  always @(posedge clk) begin
    pin <= #1 {NPIN{want}} ^ pol;
  end
endmodule

// ---- tb/osm_top_asserts.sv ----
// Concurrent checks on the output sync and mute controller ports.
`timescale 1ns/1ps
module osm_top_asserts import osm_pkg::*; (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     global_align_enable,
  input wire logic                     software_align_trigger,
  input wire logic [NCH-1:0]           divider_align_enable,
  input wire logic [NCH-1:0]           sysref_divider_align_enable,
  input wire logic [NCH-1:0]           output_mute_enable,
  input wire logic [NCH-1:0][SELW-1:0] channel_source_select,
  input wire logic [NCH-1:0][11:0]     channel_divide_ratio,
  input wire logic [NSRC-1:0]          postdiv_align_enable,
  input wire logic [NSRC-1:0]          analog_pll_locked,
  input wire logic [NSRC-1:0]          mute_on_analog_pll_unlock,
  input wire logic [NCH-1:0]           channel_divider_reset,
  input wire logic [NCH-1:0]           sysref_divider_reset,
  input wire logic [NCH-1:0]           channel_clock_out,
  input wire logic [NSRC-1:0]          postdiv_reset,
  input wire logic [NSRC-1:0]          source_valid,
  input wire logic                     sync_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Hold entry, group release and the enables that gate them; channel 5 is the bypass one.
  a_hold_entry: assert property ($rose(software_align_trigger) && global_align_enable
    && postdiv_align_enable[0] |-> ##2 postdiv_reset[0] && sync_active) else $error("no hold");
  a_held_low: assert property (channel_divider_reset[0] |-> !channel_clock_out[0])
    else $error("held clock not low");
  a_group_release: assert property ($fell(channel_divider_reset[0])
    && $past(channel_divider_reset[1]) && channel_source_select[1] == channel_source_select[0]
    |-> !channel_divider_reset[1]) else $error("group split on release");
  // Channel 4 shares source 0 but is not alignment-enabled, so the held group must skip it.
  a_unaligned_free: assert property (!$past(divider_align_enable[4])
    |-> !channel_divider_reset[4]) else $error("unaligned channel held");
  // Resets are registered, so they answer to the enables of the edge before.
  a_sysref_pair: assert property (sysref_divider_reset[0]
    |-> $past(divider_align_enable[0]) && $past(sysref_divider_align_enable[0]))
    else $error("sysref held");
  a_global_gate: assert property (!global_align_enable [*3] |-> postdiv_reset == '0)
    else $error("reset with global off");
  a_bypass_free: assert property (channel_divide_ratio[5] == DIV_BYPASS
    |-> !channel_divider_reset[5]) else $error("bypass divider held");
  a_mute_unlock: assert property ((output_mute_enable[0] && mute_on_analog_pll_unlock[0]
    && !analog_pll_locked[0] && channel_source_select[0] == 2'h0) [*3]
    |-> !channel_clock_out[0] && !source_valid[0]) else $error("unlocked source not muted");

  // Main scenarios reached.
  c_hold: cover property ($rose(sync_active));
  c_invalid: cover property ($fell(source_valid[0]));
  c_release: cover property ($fell(channel_divider_reset[0]));
endmodule

bind osm_top osm_top_asserts u_asserts (.*);

// ---- tb/osm_top_tb.sv ----
// Self-checking bench for the output sync and mute controller.
`timescale 1ns/1ps
module osm_top_tb;
  import osm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic global_align_enable, software_align_trigger, want, sync_active;
  logic [NPIN-1:0][5:0] pin_function_select;
  logic [NPIN-1:0] pin_polarity_invert, pin_in, pin_output_enable, pin_out, pin_oe;
  logic [NCH-1:0] divider_align_enable, sysref_divider_align_enable, sysref_pin_replicate_enable;
  logic [NCH-1:0] output_mute_enable, channel_clock_in, sysref_static_delayed_in;
  logic [NCH-1:0] channel_divider_reset, sysref_divider_reset, channel_clock_out;
  logic [NCH-1:0][SELW-1:0] channel_source_select;
  logic [NCH-1:0][11:0] channel_divide_ratio;
  logic [NSRC-1:0] postdiv_align_enable, analog_pll_locked, digital_pll_freq_locked;
  logic [NSRC-1:0] digital_pll_phase_locked, mute_on_analog_pll_unlock, postdiv_reset;
  logic [NSRC-1:0] mute_on_digital_pll_unlock, mute_on_digital_phase_unlock, source_valid;
  osm_cmos_mode_t [NCMOS-1:0] cmos_p_mode, cmos_n_mode;
  logic [NCMOS-1:0] cmos_p_out, cmos_p_oe, cmos_n_out, cmos_n_oe;
  logic [9:0] act, last;
  int errors, tests_run;
  wire [9:0] now = {pin_out[1], cmos_p_out[0], channel_clock_out};

  osm_top dut (.*);
  osm_host_src host (.clk(clk), .want(want), .pol(pin_polarity_invert), .pin(pin_in));

  // Half-period toggle gives the 5 ns clock.
  always #2.5 clk = ~clk;

  // Source clocks toggle each cycle; any change on a watched output is remembered.
  always @(posedge clk) begin
    channel_clock_in <= #1 ~channel_clock_in;
    sysref_static_delayed_in <= #1 ~sysref_static_delayed_in;
    act <= act | (now ^ last);
    last <= now;
  end

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Channel clocks toggle every cycle; activity is judged over a 24-cycle window.
  task watch;
    act = '0;
    cyc(24);
  endtask

  task chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Channels 0,1,5 on source 0, 2 on source 1, 3 on 2, 6,7 on 3; 4 unaligned on source 0.
  initial begin
    errors = 0;
    tests_run = 0;
    {global_align_enable, software_align_trigger, want} = 3'h4;
    {pin_function_select, pin_polarity_invert, pin_output_enable} = '0;
    {act, last, channel_clock_in, sysref_static_delayed_in} = '0;
    {analog_pll_locked, digital_pll_freq_locked, digital_pll_phase_locked} = '1;
    {mute_on_analog_pll_unlock, mute_on_digital_pll_unlock, mute_on_digital_phase_unlock} = '1;
    divider_align_enable = 8'h27;
    sysref_divider_align_enable = 8'h0b;
    sysref_pin_replicate_enable = 8'h00;
    output_mute_enable = 8'hff;
    channel_source_select = 16'hf090;
    channel_divide_ratio = {{2{12'h004}}, DIV_BYPASS, {5{12'h004}}};
    postdiv_align_enable = 4'h3;
    cmos_p_mode[0] = OSM_CMOS_NORMAL;
    cmos_p_mode[1] = OSM_CMOS_NORMAL;
    cmos_n_mode[0] = OSM_CMOS_INVERT;
    cmos_n_mode[1] = OSM_CMOS_INVERT;
    cyc(16);
    rst = 1'b0;
    cyc(4);
    watch;
    chk(act[7:0], 8'hff);
    // Software hold: sources 0 and 1 are held, sources 2 and 3 keep running.
    software_align_trigger = 1'b1;
    cyc(2);
    chk(channel_divider_reset, 8'h07);
    chk(sysref_divider_reset, 8'h03);
    chk(postdiv_reset, 4'h3);
    chk(postdiv_reset[3:2], 2'h0);
    chk(sync_active, 1'b1);
    watch;
    chk(act[7:0] & 8'hdf, 8'hc8);
    software_align_trigger = 1'b0;
    cyc(2);
    chk(channel_divider_reset, 8'h00);
    watch;
    chk(act[7:0], 8'hff);
    // Pin trigger in both polarities, then with a pin code that is not the sync code.
    for (int i = 0; i < 3; i++) begin
      pin_function_select[0] = (i < 2) ? PIN_FUNC_SYNC : 6'h1e;
      pin_polarity_invert = {2{i == 1}};
      cyc(8);
      want = 1'b1;
      cyc(8);
      chk(channel_divider_reset[0], i < 2);
      want = 1'b0;
      cyc(8);
      chk(channel_divider_reset[0], 1'b0);
    end
    global_align_enable = 1'b0;
    software_align_trigger = 1'b1;
    cyc(4);
    chk(postdiv_reset, 4'h0);
    software_align_trigger = 1'b0;
    global_align_enable = 1'b1;
    cyc(4);
    // Loss of lock on source 0 mutes its channels unless masked or mute is off.
    analog_pll_locked = 4'he;
    cyc(3);
    chk(source_valid, 4'he);
    watch;
    chk(act[7:0], 8'hcc);
    output_mute_enable = 8'hfe;
    watch;
    chk(act[7:0], 8'hcd);
    mute_on_analog_pll_unlock = 4'he;
    cyc(3);
    chk(source_valid, 4'hf);
    digital_pll_freq_locked = 4'he;
    cyc(3);
    chk(source_valid, 4'he);
    mute_on_digital_pll_unlock = 4'he;
    cyc(3);
    chk(source_valid, 4'hf);
    // CMOS pin modes on channel 0.
    cmos_p_mode[0] = OSM_CMOS_LOW;
    cyc(2);
    chk({cmos_p_oe[0], cmos_p_out[0]}, 2'h2);
    cmos_p_mode[0] = OSM_CMOS_HIZ;
    cyc(2);
    chk(cmos_p_oe[0], 1'b0);
    cmos_p_mode[0] = OSM_CMOS_NORMAL;
    cyc(2);
    chk({cmos_p_oe[0], cmos_n_oe[0], cmos_p_out[0] ^ cmos_n_out[0]}, 3'h7);
    // Replica of channel 0 sysref on pin 1.
    pin_function_select = '0;
    pin_output_enable = 2'h2;
    sysref_pin_replicate_enable = 8'h01;
    cyc(3);
    chk(pin_oe, 2'h2);
    watch;
    chk(act[9:8], 2'h3);
    pin_output_enable = 2'h0;
    cyc(3);
    chk(pin_oe, 2'h0);
    conclude;
  end
endmodule
